// ### inc/sync_capture_pkg.sv
// Shared constants and types for the synchronous port capture block.
package sync_capture_pkg;

   localparam int NUM_PORTS  = 12;
   localparam int PORT_W     = 8;
   localparam int WORD_W     = 16;
   localparam int DEPTH      = 256;
   localparam int ADDR_W     = 8;
   localparam int VEC_W      = 9;
   localparam int PORT_IDX_W = 4;
   localparam int SEL_W      = 3;
   localparam int NSEL_W     = 4;

   localparam logic [PORT_IDX_W-1:0] PORT_LAST    = 4'hB;
   localparam logic [PORT_IDX_W-1:0] PAIR_TOGGLE  = 4'h1;
   localparam logic [PORT_IDX_W:0]   SYNC_MAX     = 5'h0C;
   localparam logic [VEC_W-1:0]      VEC_MAX      = 9'h100;
   localparam logic [VEC_W-1:0]      VEC_STEP     = 9'h001;
   localparam logic [NSEL_W-1:0]     NSEL_MAX     = 4'h8;
   localparam logic [NSEL_W-1:0]     NSEL_MIN     = 4'h1;
   localparam logic [PORT_W-1:0]     BYTE_ZERO    = 8'h00;
   localparam logic [WORD_W-1:0]     WORD_ZERO    = 16'h0000;

   // Per-port operating mode; one-hot so that the idle state is never all zero.
   typedef enum logic [5:0] {
      MODE_IDLE    = 6'h01,
      MODE_BYTE    = 6'h02,
      MODE_WORD_LO = 6'h04,
      MODE_WORD_HI = 6'h08,
      MODE_BIT     = 6'h10,
      MODE_OFF     = 6'h20
   } port_mode_t;

   // Width designator of a read setup request.
   typedef enum logic [1:0] {
      WIDTH_NONE = 2'h0,
      WIDTH_BYTE = 2'h1,
      WIDTH_WORD = 2'h2,
      WIDTH_BIT  = 2'h3
   } width_t;

   // Presentation of buffered data when it is read back.
   typedef enum logic [1:0] {
      FMT_DEC = 2'h0,
      FMT_BIN = 2'h1,
      FMT_HEX = 2'h2
   } format_t;

   typedef struct packed {
      logic [PORT_IDX_W-1:0]       port;
      width_t                      width;
      format_t                     format;
      logic [PORT_W-1:0][SEL_W-1:0] bit_sel;
      logic [NSEL_W-1:0]           bit_count;
      logic [VEC_W-1:0]            vectors;
   } setup_req_t;

   typedef struct packed {
      port_mode_t                  mode;
      format_t                     format;
      logic [PORT_W-1:0][SEL_W-1:0] bit_sel;
      logic [NSEL_W-1:0]           bit_count;
      logic [VEC_W-1:0]            vectors;
      logic [VEC_W-1:0]            count;
   } port_cfg_t;

   localparam port_cfg_t CFG_RESET = '{mode: MODE_IDLE, format: FMT_DEC, bit_sel: '0,
                                       bit_count: '0, vectors: '0, count: '0};

endpackage

// ### rtl/capture_buffer.sv
// Vector store of one port: one write port, one registered read port.
`timescale 1ns/100ps
module capture_buffer
(
   input  wire logic                                   clk,
   input  wire logic                                   rst_b,
   input  wire logic                                   wr_en,
   input  wire logic [sync_capture_pkg::ADDR_W-1:0]    wr_addr,
   input  wire logic [sync_capture_pkg::PORT_W-1:0]    wr_data,
   input  wire logic [sync_capture_pkg::ADDR_W-1:0]    rd_addr,
   output logic      [sync_capture_pkg::PORT_W-1:0]    rd_data
);

   typedef struct packed {
      logic [sync_capture_pkg::PORT_W-1:0] rd_data;
   } buffer_state_t;

   logic [sync_capture_pkg::PORT_W-1:0] mem [sync_capture_pkg::DEPTH];
   buffer_state_t                       s;
   buffer_state_t                       next_s;

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      next_s         = s;
      next_s.rd_data = mem[rd_addr];
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         s <= '0;
      else
         s <= next_s;
   end

   // The array has no reset; stale words are masked by the owner's count.
   always_ff @(posedge clk)
   begin
      if (wr_en)
         mem[wr_addr] <= wr_data;
   end

   assign rd_data = s.rd_data;

endmodule

// ### rtl/sync_port_capture.sv
// Synchronous buffered-read side of a twelve-port 8-bit digital I/O block.
//
// Function
// - No width designator means byte capture.
// - Decimal presentation unless binary or hex chosen.
// - Word port narrowed: companion cleared and disabled.
// - Word capture pairs ports, even port only.
// - Even port low byte, odd port high.
// - Word pair never mixes byte or bit.
// - Bit capture stores only selected lines.
// - Selected lines stored in listed order.
// - Synchronous port count accepted from 0 to 12.
// - Synchronous ports contiguous from port zero.
// - Power-up: all ports asynchronous, test disarmed.
// - Ports changing mode lose format and data.
// - Only synchronous ports transfer on sample clock.
// - Sync ports: async write works, async read refused.
// - Armed: sample each rising edge, up to 256.
// - All ports finished: test disarms itself.
`timescale 1ns/100ps
module sync_port_capture
(
   input  wire logic                                                        clk,
   input  wire logic                                                        rst_b,
   input  wire logic [sync_capture_pkg::NUM_PORTS-1:0][sync_capture_pkg::PORT_W-1:0] port_in,
   input  wire logic                                                        external_sample_clock,
   input  wire logic                                                        sync_count_wr,
   input  wire logic [sync_capture_pkg::PORT_IDX_W:0]                       sync_count,
   input  wire logic                                                        setup_wr,
   input  wire sync_capture_pkg::setup_req_t                                setup_req,
   input  wire logic                                                        arm_on,
   input  wire logic                                                        arm_off,
   input  wire logic                                                        async_wr,
   input  wire logic                                                        async_rd,
   input  wire logic [sync_capture_pkg::PORT_IDX_W-1:0]                     async_port,
   input  wire logic [sync_capture_pkg::PORT_W-1:0]                         async_data,
   input  wire logic                                                        buffer_readback_command,
   input  wire logic [sync_capture_pkg::PORT_IDX_W-1:0]                     readback_port,
   input  wire logic [sync_capture_pkg::ADDR_W-1:0]                         readback_index,
   output logic      [sync_capture_pkg::NUM_PORTS-1:0][sync_capture_pkg::PORT_W-1:0] port_value,
   output logic      [sync_capture_pkg::NUM_PORTS-1:0]                      sync_mask,
   output logic                                                             armed,
   output logic                                                             busy,
   output logic                                                             test_done,
   output logic                                                             setup_error,
   output logic                                                             sync_error,
   output logic                                                             async_rd_valid,
   output logic                                                             async_rd_refused,
   output logic      [sync_capture_pkg::PORT_W-1:0]                         async_rd_data,
   output logic                                                             readback_valid,
   output logic                                                             readback_refused,
   output logic      [sync_capture_pkg::WORD_W-1:0]                         readback_data,
   output sync_capture_pkg::format_t                                        readback_format
);

   localparam int NP = sync_capture_pkg::NUM_PORTS;
   localparam int PW = sync_capture_pkg::PORT_W;

   typedef struct packed {
      logic [NP-1:0]                              sync_mask;
      logic                                       armed;
      logic                                       test_done;
      sync_capture_pkg::port_cfg_t [NP-1:0]       cfg;
      logic [NP-1:0][PW-1:0]                      port_value;
      logic [NP-1:0][PW-1:0]                      pin_meta;
      logic [NP-1:0][PW-1:0]                      pin_sync;
      logic                                       sclk_meta;
      logic                                       sclk_sync;
      logic                                       sclk_prev;
      logic                                       setup_error;
      logic                                       sync_error;
      logic                                       rd_valid;
      logic                                       rd_refused;
      logic [PW-1:0]                              rd_data;
      logic                                       rb_pend;
      logic                                       rb_fetch;
      logic [sync_capture_pkg::PORT_IDX_W-1:0]    rb_port;
      logic [sync_capture_pkg::ADDR_W-1:0]        rb_index;
      logic                                       rb_valid;
      logic                                       rb_refused;
      logic [sync_capture_pkg::WORD_W-1:0]        rb_data;
      sync_capture_pkg::format_t                  rb_format;
   } capture_state_t;

   capture_state_t        s;
   capture_state_t        next_s;
   logic                  sclk_rise;
   logic [NP-1:0]         active;
   logic [NP-1:0]         capture_en;
   logic [NP-1:0][PW-1:0] capture_data;
   logic [NP-1:0][PW-1:0] buf_q;

   // Gathers the selected lines into the low bits in the order they were listed.
   function automatic logic [PW-1:0] pack_bits(input logic [PW-1:0] lines,
                                               input logic [PW-1:0][sync_capture_pkg::SEL_W-1:0] sel,
                                               input logic [sync_capture_pkg::NSEL_W-1:0] n);
      logic [PW-1:0] r;
      r = sync_capture_pkg::BYTE_ZERO;
      for (int k = 0; k < PW; k++)
      begin
         if (sync_capture_pkg::NSEL_W'(k) < n)
            r[k] = lines[sel[k]];
      end
      return r;
   endfunction

   assign sclk_rise = s.sclk_sync && !s.sclk_prev;

   ////////////////////////////////////////////////////////////////////////////
   // Per-port capture path and vector store.
   for (genvar i = 0; i < NP; i++)
   begin : g_port
      assign active[i] = s.sync_mask[i]
                         && (s.cfg[i].mode inside {sync_capture_pkg::MODE_BYTE, sync_capture_pkg::MODE_BIT,
                                                   sync_capture_pkg::MODE_WORD_LO, sync_capture_pkg::MODE_WORD_HI})
                         && (s.cfg[i].count < s.cfg[i].vectors);
      assign capture_en[i] = s.armed && sclk_rise && active[i];
      assign capture_data[i] = (s.cfg[i].mode == sync_capture_pkg::MODE_BIT)
                               ? pack_bits(s.pin_sync[i], s.cfg[i].bit_sel, s.cfg[i].bit_count)
                               : s.pin_sync[i];

      capture_buffer u_buffer
      (
         .clk     (clk),
         .rst_b   (rst_b),
         .wr_en   (capture_en[i]),
         .wr_addr (s.cfg[i].count[sync_capture_pkg::ADDR_W-1:0]),
         .wr_data (capture_data[i]),
         .rd_addr (s.rb_index),
         .rd_data (buf_q[i])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      logic [sync_capture_pkg::PORT_IDX_W-1:0] p;
      logic [sync_capture_pkg::PORT_IDX_W-1:0] c;
      logic [NP-1:0]                           new_mask;
      logic [NP-1:0]                           changed;
      logic                                    ok;
      p        = setup_req.port;
      c        = setup_req.port ^ sync_capture_pkg::PAIR_TOGGLE;
      new_mask = '0;
      changed  = '0;
      ok       = 1'b0;
      next_s   = s;

      next_s.pin_meta    = port_in;
      next_s.pin_sync    = s.pin_meta;
      next_s.sclk_meta   = external_sample_clock;
      next_s.sclk_sync   = s.sclk_meta;
      next_s.sclk_prev   = s.sclk_sync;
      next_s.test_done   = 1'b0;
      next_s.setup_error = 1'b0;
      next_s.sync_error  = 1'b0;
      next_s.rd_valid    = 1'b0;
      next_s.rd_refused  = 1'b0;
      next_s.rb_valid    = 1'b0;
      next_s.rb_refused  = 1'b0;
      next_s.rb_fetch    = s.rb_pend;
      next_s.rb_pend     = 1'b0;

      // Capture and automatic disarm.
      for (int i = 0; i < NP; i++)
      begin
         if (capture_en[i])
            next_s.cfg[i].count = s.cfg[i].count + sync_capture_pkg::VEC_STEP;
      end
      if (s.armed && !(|active))
      begin
         next_s.armed     = 1'b0;
         next_s.test_done = 1'b1;
      end
      if (arm_off)
         next_s.armed = 1'b0;
      else if (arm_on && !s.armed)
      begin
         next_s.armed = 1'b1;
         for (int i = 0; i < NP; i++)
            next_s.cfg[i].count = '0;
      end

      // Asynchronous access.
      if (async_wr && async_port <= sync_capture_pkg::PORT_LAST)
         next_s.port_value[async_port] = async_data;
      if (async_rd)
      begin
         if (async_port > sync_capture_pkg::PORT_LAST || s.sync_mask[async_port])
            next_s.rd_refused = 1'b1;
         else
         begin
            next_s.rd_valid = 1'b1;
            next_s.rd_data  = s.pin_sync[async_port];
         end
      end

      // Synchronous port count.
      if (sync_count_wr)
      begin
         if (s.armed || sync_count > sync_capture_pkg::SYNC_MAX)
            next_s.sync_error = 1'b1;
         else
         begin
            for (int i = 0; i < NP; i++)
               new_mask[i] = (i < int'(sync_count));
            changed          = new_mask ^ s.sync_mask;
            next_s.sync_mask = new_mask;
            for (int i = 0; i < NP; i++)
            begin
               if (changed[i])
                  next_s.cfg[i] = sync_capture_pkg::CFG_RESET;
               else if (changed[i ^ 1] && (s.cfg[i].mode inside {sync_capture_pkg::MODE_WORD_LO,
                                                                 sync_capture_pkg::MODE_WORD_HI}))
               begin
                  next_s.cfg[i]      = sync_capture_pkg::CFG_RESET;
                  next_s.cfg[i].mode = sync_capture_pkg::MODE_OFF;
               end
            end
         end
      end

      // Read setup of one synchronous port.
      else if (setup_wr)
      begin
         ok = !s.armed && p <= sync_capture_pkg::PORT_LAST && s.sync_mask[p]
              && setup_req.vectors <= sync_capture_pkg::VEC_MAX;
         if (setup_req.width == sync_capture_pkg::WIDTH_WORD)
            ok = ok && !p[0] && s.sync_mask[c];
         if (setup_req.width == sync_capture_pkg::WIDTH_BIT)
            ok = ok && setup_req.bit_count >= sync_capture_pkg::NSEL_MIN
                    && setup_req.bit_count <= sync_capture_pkg::NSEL_MAX;
         if (!ok)
            next_s.setup_error = 1'b1;
         else
         begin
            next_s.cfg[p]         = sync_capture_pkg::CFG_RESET;
            next_s.cfg[p].format  = setup_req.format;
            next_s.cfg[p].vectors = setup_req.vectors;
            if (setup_req.width == sync_capture_pkg::WIDTH_WORD)
            begin
               next_s.cfg[p].mode    = sync_capture_pkg::MODE_WORD_LO;
               next_s.cfg[c]         = next_s.cfg[p];
               next_s.cfg[c].mode    = sync_capture_pkg::MODE_WORD_HI;
            end
            else
            begin
               if (setup_req.width == sync_capture_pkg::WIDTH_BIT)
               begin
                  next_s.cfg[p].mode      = sync_capture_pkg::MODE_BIT;
                  next_s.cfg[p].bit_sel   = setup_req.bit_sel;
                  next_s.cfg[p].bit_count = setup_req.bit_count;
               end
               else
                  next_s.cfg[p].mode = sync_capture_pkg::MODE_BYTE;
               if (c <= sync_capture_pkg::PORT_LAST
                   && (s.cfg[p].mode inside {sync_capture_pkg::MODE_WORD_LO, sync_capture_pkg::MODE_WORD_HI}))
               begin
                  next_s.cfg[c]      = sync_capture_pkg::CFG_RESET;
                  next_s.cfg[c].mode = sync_capture_pkg::MODE_OFF;
               end
            end
         end
      end

      // Buffer readback: taken, fetched from the stores, then presented.
      if (buffer_readback_command)
      begin
         if (s.armed || s.rb_pend || s.rb_fetch || readback_port > sync_capture_pkg::PORT_LAST
             || !(s.cfg[readback_port].mode inside {sync_capture_pkg::MODE_BYTE, sync_capture_pkg::MODE_BIT,
                                                    sync_capture_pkg::MODE_WORD_LO}))
            next_s.rb_refused = 1'b1;
         else
         begin
            next_s.rb_pend  = 1'b1;
            next_s.rb_port  = readback_port;
            next_s.rb_index = readback_index;
         end
      end
      if (s.rb_fetch)
      begin
         next_s.rb_valid  = 1'b1;
         next_s.rb_format = s.cfg[s.rb_port].format;
         if ({1'b0, s.rb_index} >= s.cfg[s.rb_port].count)
            next_s.rb_data = sync_capture_pkg::WORD_ZERO;
         else if (s.cfg[s.rb_port].mode == sync_capture_pkg::MODE_WORD_LO)
            next_s.rb_data = {buf_q[s.rb_port ^ sync_capture_pkg::PAIR_TOGGLE], buf_q[s.rb_port]};
         else
            next_s.rb_data = {sync_capture_pkg::BYTE_ZERO, buf_q[s.rb_port]};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s     <= '0;
         s.cfg <= {NP{sync_capture_pkg::CFG_RESET}};
      end
      else
         s <= next_s;
   end

   assign port_value       = s.port_value;
   assign sync_mask        = s.sync_mask;
   assign armed            = s.armed;
   assign busy             = s.armed;
   assign test_done        = s.test_done;
   assign setup_error      = s.setup_error;
   assign sync_error       = s.sync_error;
   assign async_rd_valid   = s.rd_valid;
   assign async_rd_refused = s.rd_refused;
   assign async_rd_data    = s.rd_data;
   assign readback_valid   = s.rb_valid;
   assign readback_refused = s.rb_refused;
   assign readback_data    = s.rb_data;
   assign readback_format  = s.rb_format;

endmodule

// ### testbench/ext_source.sv
// Behavioural external source driving the capture clock and the port pins.
`timescale 1ns/100ps
module ext_source
(
   input  wire logic             go,
   input  wire logic [3:0]       n,
   output logic                  sample_clk,
   output logic [11:0][7:0]      pins
);
   initial
   begin
      sample_clk = 1'h0;
      pins = '1;
   end

   // The clock runs only inside a frame; afterwards the pins are inverted so stale values never pass.
   always @(posedge go)
   begin
      for (int i = 0; i < n; i++)
      begin
         for (int k = 0; k < 12; k++)
            pins[k] = 8'hA5 ^ {4'(k), 4'(i)};
         #80 sample_clk = 1'h1;
         #160 sample_clk = 1'h0;
         #80;
      end
      pins = ~pins;
   end
endmodule

// ### testbench/sync_port_capture_chk.sv
// Assertion checker for the synchronous port capture block.
`timescale 1ns/100ps
module sync_port_capture_chk
(
   input wire logic                    clk,
   input wire logic                    rst_b,
   input wire logic                    sync_count_wr,
   input wire logic [4:0]              sync_count,
   input wire logic                    arm_on,
   input wire logic                    arm_off,
   input wire logic                    async_wr,
   input wire logic                    async_rd,
   input wire logic [3:0]              async_port,
   input wire logic [7:0]              async_data,
   input wire logic                    buffer_readback_command,
   input wire logic [11:0][7:0]        port_value,
   input wire logic [11:0]             sync_mask,
   input wire logic                    armed,
   input wire logic                    busy,
   input wire logic                    test_done,
   input wire logic                    sync_error,
   input wire logic                    async_rd_valid,
   input wire logic                    async_rd_refused,
   input wire logic                    readback_refused
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence s_rd_sync;
      async_rd && async_port < 4'hC && sync_mask[async_port];
   endsequence
   sequence s_rd_async;
      async_rd && async_port < 4'hC && !sync_mask[async_port];
   endsequence
   sequence s_wr;
      async_wr && async_port < 4'hC;
   endsequence

   property p_contig; (sync_mask & (sync_mask + 12'h001)) == 12'h000; endproperty
   property p_busy; busy == armed; endproperty
   property p_start; $rose(rst_b) |-> sync_mask == 12'h000 && !armed; endproperty
   property p_arm; $rose(armed) |-> $past(arm_on) && !$past(arm_off); endproperty
   property p_done; test_done |-> !armed && $past(armed); endproperty
   property p_count; sync_count_wr && sync_count <= 5'h0C && !armed |=> $countones(sync_mask) == $past(sync_count);
   endproperty
   property p_sync_err; sync_count_wr && sync_count > 5'h0C |=> sync_error && $stable(sync_mask); endproperty
   property p_rd_refuse; s_rd_sync |=> async_rd_refused && !async_rd_valid; endproperty
   property p_rd_ok; s_rd_async |=> async_rd_valid && !async_rd_refused; endproperty
   property p_wr; s_wr |=> port_value[$past(async_port)] == $past(async_data); endproperty
   property p_rb_armed; buffer_readback_command && armed |=> readback_refused; endproperty

   a_contig: assert property (p_contig) else $error("sync mask not contiguous from port zero");
   a_busy: assert property (p_busy) else $error("busy differs from armed");
   a_start: assert property (p_start) else $error("not idle after reset");
   a_arm: assert property (p_arm) else $error("armed without arm command");
   a_done: assert property (p_done) else $error("done pulse without disarm");
   a_count: assert property (p_count) else $error("sync mask count wrong");
   a_sync_err: assert property (p_sync_err) else $error("bad sync count accepted");
   a_rd_refuse: assert property (p_rd_refuse) else $error("async read of sync port served");
   a_rd_ok: assert property (p_rd_ok) else $error("async read of async port not served");
   a_wr: assert property (p_wr) else $error("async write lost");
   a_rb_armed: assert property (p_rb_armed) else $error("readback served while armed");
endmodule

bind sync_port_capture sync_port_capture_chk chk (.clk, .rst_b, .sync_count_wr, .sync_count, .arm_on, .arm_off,
   .async_wr, .async_rd, .async_port, .async_data, .buffer_readback_command, .port_value, .sync_mask, .armed, .busy,
   .test_done, .sync_error, .async_rd_valid, .async_rd_refused, .readback_refused);

// ### testbench/sync_port_capture_tb.sv
// Self-checking testbench for the synchronous port capture block.
`timescale 1ns/100ps
module sync_port_capture_tb;
   logic                         clk = 1'h0;
   logic                         rst_b = 1'h0;
   logic                         go, external_sample_clock, sync_count_wr, setup_wr, arm_on, arm_off;
   logic                         async_wr, async_rd, buffer_readback_command, busy, test_done, setup_error;
   logic                         armed, sync_error, async_rd_valid, async_rd_refused, readback_valid, readback_refused;
   logic [11:0][7:0]             port_in, port_value;
   logic [11:0]                  sync_mask;
   logic [4:0]                   sync_count;
   logic [3:0]                   async_port, readback_port;
   logic [7:0]                   async_data, readback_index, async_rd_data;
   logic [15:0]                  readback_data;
   sync_capture_pkg::format_t    readback_format;
   sync_capture_pkg::setup_req_t setup_req;
   int                           num_errors = 0;
   int                           comparisons = 0;
   int                           cycles = 0;
   localparam logic [17:0]       ROWS [5] = '{{5'h00, 12'h000, 1'h0}, {5'h01, 12'h001, 1'h0},
      {5'h0C, 12'hFFF, 1'h0}, {5'h0D, 12'hFFF, 1'h1}, {5'h05, 12'h01F, 1'h0}};

   sync_port_capture uut (.clk, .rst_b, .port_in, .external_sample_clock, .sync_count_wr, .sync_count, .setup_wr,
      .setup_req, .arm_on, .arm_off, .async_wr, .async_rd, .async_port, .async_data, .buffer_readback_command,
      .readback_port, .readback_index, .port_value, .sync_mask, .armed, .busy, .test_done, .setup_error, .sync_error,
      .async_rd_valid, .async_rd_refused, .async_rd_data, .readback_valid, .readback_refused, .readback_data,
      .readback_format);
   ext_source src (.go, .n(4'h2), .sample_clk(external_sample_clock), .pins(port_in));

   always #20 clk = ~clk;

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         num_errors++;
         end_of_test;
      end
   end

   function automatic logic [7:0] pat(input int k, input int i);
      return 8'hA5 ^ {4'(k), 4'(i)};
   endfunction

   task step;
      @(negedge clk);
   endtask

   task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task sync(input logic [4:0] c);
      sync_count = c;
      sync_count_wr = 1'h1;
      step;
      sync_count_wr = 1'h0;
   endtask

   task setup(input logic [3:0] p, input logic [1:0] w, input logic [1:0] f, input logic [23:0] sel,
              input logic [3:0] n, input logic [8:0] v, input logic err);
      setup_req = {p, w, f, sel, n, v};
      setup_wr = 1'h1;
      step;
      setup_wr = 1'h0;
      chk("setup_error", setup_error, err);
   endtask

   task rb(input logic [3:0] p, input logic [7:0] i, input logic [15:0] exp, input logic [1:0] f, input logic refuse);
      readback_port = p;
      readback_index = i;
      buffer_readback_command = 1'h1;
      step;
      buffer_readback_command = 1'h0;
      for (int c = 0; c < 4 && readback_valid !== 1'h1 && readback_refused !== 1'h1; c++)
         step;
      chk("readback_refused", readback_refused, refuse);
      chk("readback_valid", readback_valid, !refuse);
      if (!refuse)
      begin
         chk("readback_data", readback_data, exp);
         chk("readback_format", readback_format, f);
      end
      repeat (2) step;
   endtask

   task end_of_test;
      if (num_errors == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial
   begin
      {go, sync_count_wr, setup_wr, arm_on, arm_off, async_wr, async_rd, buffer_readback_command} = '0;
      {sync_count, setup_req, async_port, async_data, readback_port, readback_index} = '0;
      repeat (2) step;
      rst_b = 1'h1;
      chk("sync_mask", sync_mask, 16'h0000);
      chk("armed", armed, 16'h0000);
      foreach (ROWS[r])
      begin
         sync(ROWS[r][17:13]);
         chk("sync_error", sync_error, ROWS[r][0]);
         chk("sync_mask", sync_mask, ROWS[r][12:1]);
      end
      setup(4'h0, 2'h0, 2'h2, 24'h0, 4'h0, 9'h002, 1'h0);
      setup(4'h1, 2'h1, 2'h0, 24'h0, 4'h0, 9'h000, 1'h0);
      setup(4'h2, 2'h2, 2'h1, 24'h0, 4'h0, 9'h002, 1'h0);
      setup(4'h3, 2'h2, 2'h0, 24'h0, 4'h0, 9'h002, 1'h1);
      setup(4'h4, 2'h3, 2'h0, {15'h0, 3'h5, 3'h0, 3'h1}, 4'h3, 9'h002, 1'h0);
      arm_on = 1'h1;
      step;
      arm_on = 1'h0;
      chk("busy", busy, 16'h0001);
      go = 1'h1;
      for (int c = 0; c < 100 && test_done !== 1'h1; c++)
         step;
      go = 1'h0;
      chk("test_done", test_done, 16'h0001);
      chk("armed", armed, 16'h0000);
      rb(4'h0, 8'h00, {8'h00, pat(0, 0)}, 2'h2, 1'h0);
      rb(4'h2, 8'h01, {pat(3, 1), pat(2, 1)}, 2'h1, 1'h0);
      rb(4'h4, 8'h00, 16'h0006, 2'h0, 1'h0);
      rb(4'h3, 8'h00, 16'h0000, 2'h0, 1'h1);
      rb(4'h1, 8'h00, 16'h0000, 2'h0, 1'h0);
      {async_rd, async_port} = {1'h1, 4'h0};
      step;
      chk("async_rd_refused", async_rd_refused, 16'h0001);
      async_port = 4'h7;
      step;
      chk("async_rd_data", async_rd_data, {8'h00, ~pat(7, 1)});
      {async_rd, async_wr, async_port, async_data} = {1'h0, 1'h1, 4'h0, 8'h5A};
      step;
      async_wr = 1'h0;
      chk("port_value", port_value[0], 16'h005A);
      setup(4'h2, 2'h1, 2'h0, 24'h0, 4'h0, 9'h001, 1'h0);
      rb(4'h3, 8'h00, 16'h0000, 2'h0, 1'h1);
      sync(5'h01);
      sync(5'h05);
      rb(4'h4, 8'h00, 16'h0000, 2'h0, 1'h1);
      arm_on = 1'h1;
      step;
      arm_on = 1'h0;
      rb(4'h0, 8'h00, 16'h0000, 2'h0, 1'h1);
      arm_off = 1'h1;
      step;
      arm_off = 1'h0;
      step;
      chk("armed", armed, 16'h0000);
      end_of_test;
   end
endmodule
